/* src/setpoint_relay_mask_regs.sv */
// Latch flags, relay release mask, memory size code and setpoint state view.
// Assumes setpoint activity and panel actions are synchronous to i_sys_clk.
//
// Summary of operation
// - Latch register bits 0..5 hold latched state of setpoints 1..6; bits 6,7 unused.
// - Latched setpoint stays latched until software writes zero to its bit.
// - Release mask bit is set whenever its de-energise setpoint is inactive.
// - While active and gated (cfg bit set), relay energised only when mask bit AND relay state is 1.
// - Clearing mask bit while a gated setpoint (cfg bit set) is active de-energises that relay.
// - When setpoint returns inactive, mask bit is set back to one.
// - Front-panel de-energise clears mask bit exactly as a register write.
// - Mask bits 0..5 map to relays 1..6; bits 6,7 don't care.
// - On memory re-initialisation the probed size code is stored read-only.
// - Size code zero means no memory reachable, an error.
// - Size codes two and four mean invalid memory type, errors.
// - Codes 1,8,16,32,64,128 report increasing supported capacities.
// - Read-only state view bits 0..2 show live status of setpoints 1..3.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "sprm_defs.svh"
module setpoint_relay_mask_regs (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic [5:0] i_sp_active,
	input wire logic [5:0] i_sp_latch_event,
	input wire logic [5:0] i_relay_state,
	input wire logic [5:0] i_panel_release,
	input wire logic i_nv_reinit_done,
	input wire logic [7:0] i_nv_size_probe,
	output logic [5:0] o_relay_drive,
	output logic [5:0] o_sp_latched,
	output logic o_nv_size_error,
	output logic o_irq
);
	localparam sprm_pkg::reg8_t latch_init = `RST_LATCH;
	localparam sprm_pkg::reg8_t mask_init = `RST_MASK;
	sprm_pkg::bus_req_t req;
	sprm_pkg::size_report_t size_rep;
	logic [5:0] latch_bits;
	logic [5:0] mask_bits;
	logic [1:0] mask_spare_ff;
	logic [5:0] drive_bits;
	logic wr_latch;
	logic wr_mask;
	logic wr_cfg;
	logic wr_irq_stat;
	logic wr_irq_mask;
	sprm_pkg::reg8_t size_ff;
	sprm_pkg::reg8_t cfg_ff;
	sprm_pkg::reg8_t irq_stat_ff;
	sprm_pkg::reg8_t irq_mask_ff;
	sprm_pkg::reg8_t rdata_ff;
	sprm_pkg::reg8_t nxt_rdata;
	sprm_pkg::reg8_t irq_set;
	logic [5:0] sp_active_d_ff;
	logic size_err_ff;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic logic size_is_error(input logic [7:0] c);
		unique case (c)
			8'h01, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80: size_is_error = 1'h0;
			default: size_is_error = 1'h1;
		endcase
	endfunction

	assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};
	assign size_rep = '{valid: i_nv_reinit_done, code: i_nv_size_probe};

	// One write enable per writable register; the read-only offsets have none
	assign wr_latch = req.wr && hit(req.addr, `OFS_LATCH_CTRL);
	assign wr_mask = req.wr && hit(req.addr, `OFS_RELEASE_MASK);
	assign wr_cfg = req.wr && hit(req.addr, `OFS_SETPOINT_CFG);
	assign wr_irq_stat = req.wr && hit(req.addr, `OFS_IRQ_STATUS);
	assign wr_irq_mask = req.wr && hit(req.addr, `OFS_IRQ_MASK);

	// Each setpoint owns one latch bit, one release mask bit and one relay drive bit
	for (genvar i = 0; i < `NUM_SETPOINTS; i++) begin : g_sp
		logic latch_ff;
		logic mask_ff;
		logic drive_ff;

		// A trip event latches the bit when its cfg bit is set, and wins over a written zero in the same cycle
		always_ff @(posedge i_sys_clk) begin
			if (i_sys_rst) begin
				latch_ff <= latch_init[i];
			end else if (i_sp_latch_event[i] && cfg_ff[i]) begin
				latch_ff <= 1'h1;
			end else if (wr_latch) begin
				latch_ff <= req.wdata[i];
			end
		end

		// Forced high while inactive, so a clear only sticks during an active setpoint
		always_ff @(posedge i_sys_clk) begin
			if (i_sys_rst) begin
				mask_ff <= mask_init[i];
			end else if (!i_sp_active[i]) begin
				mask_ff <= 1'h1;
			end else if (i_panel_release[i]) begin
				mask_ff <= 1'h0;
			end else if (wr_mask) begin
				mask_ff <= req.wdata[i];
			end
		end

		// The mask gates the relay only while a gated setpoint is active
		always_ff @(posedge i_sys_clk) begin
			if (i_sys_rst) begin
				drive_ff <= `RST_DRIVE_BIT;
			end else if (i_sp_active[i] && cfg_ff[i]) begin
				drive_ff <= mask_ff & i_relay_state[i];
			end else begin
				drive_ff <= i_relay_state[i];
			end
		end

		assign latch_bits[i] = latch_ff;
		assign mask_bits[i] = mask_ff;
		assign drive_bits[i] = drive_ff;
	end

	// Mask bits 7:6 map to no relay and are kept as plain storage
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			mask_spare_ff <= mask_init[7:6];
		end else if (wr_mask) begin
			mask_spare_ff <= req.wdata[7:6];
		end
	end

	// Setpoint configuration: bits 5:0 select latching and release gating, bits 7:6 read zero
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			cfg_ff <= `RST_CFG;
		end else if (wr_cfg) begin
			cfg_ff <= {2'h0, req.wdata[`SP_FIELD_MSB:0]};
		end
	end

	// Memory size capture, only from the re-initialisation report
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			size_ff <= `RST_SIZE;
			size_err_ff <= `RST_SIZE_ERR;
		end else if (size_rep.valid) begin
			size_ff <= size_rep.code;
			size_err_ff <= size_is_error(size_rep.code);
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			sp_active_d_ff <= `RST_ACTIVE_PREV;
		end else begin
			sp_active_d_ff <= i_sp_active;
		end
	end

	always_comb begin
		irq_set = 8'h00;
		irq_set[`IRQ_BIT_SIZE] = size_rep.valid;
		irq_set[`IRQ_BIT_SIZE_ERR] = size_rep.valid && size_is_error(size_rep.code);
		irq_set[`IRQ_BIT_PANEL] = |i_panel_release;
		irq_set[`IRQ_BIT_SP_RISE] = |(i_sp_active & ~sp_active_d_ff);
	end

	// Sticky status, write one to clear; a new event wins over the clear
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			irq_stat_ff <= `RST_IRQ_STATUS;
		end else if (wr_irq_stat) begin
			irq_stat_ff <= (irq_stat_ff & ~req.wdata) | irq_set;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_set;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			irq_mask_ff <= `RST_IRQ_MASK;
		end else if (wr_irq_mask) begin
			irq_mask_ff <= {4'h0, req.wdata[3:0]};
		end
	end

	always_comb begin
		nxt_rdata = 8'h00;
		unique case (req.addr)
			`OFS_LATCH_CTRL: nxt_rdata = {2'h0, latch_bits};
			`OFS_RELEASE_MASK: nxt_rdata = {mask_spare_ff, mask_bits};
			`OFS_NV_SIZE: nxt_rdata = size_ff;
			`OFS_STATE_VIEW: nxt_rdata = {5'h00, i_sp_active[`VIEW_FIELD_MSB:0]};
			`OFS_IRQ_STATUS: nxt_rdata = irq_stat_ff;
			`OFS_IRQ_MASK: nxt_rdata = irq_mask_ff;
			`OFS_SETPOINT_CFG: nxt_rdata = cfg_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	// Read data stands only in the cycle after the read strobe
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rdata_ff <= `RST_RDATA;
		end else if (req.rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign o_rdata = rdata_ff;
	assign o_relay_drive = drive_bits;
	assign o_sp_latched = latch_bits;
	assign o_nv_size_error = size_err_ff;
	assign o_irq = |(irq_stat_ff & irq_mask_ff);
endmodule

/* src/sprm_defs.svh */
// Register offsets, field positions, reset values and memory size codes.
// Assumes an 8-bit register address space with registers at printed offsets.
`ifndef SPRM_DEFS_SVH
`define SPRM_DEFS_SVH
`define OFS_LATCH_CTRL 8'hdd
`define OFS_RELEASE_MASK 8'hde
`define OFS_NV_SIZE 8'hdf
`define OFS_STATE_VIEW 8'he0
`define OFS_IRQ_STATUS 8'he1
`define OFS_IRQ_MASK 8'he2
`define OFS_SETPOINT_CFG 8'he3
`define NUM_SETPOINTS 6
`define SP_FIELD_MSB 5
`define VIEW_FIELD_MSB 2
`define RST_LATCH 8'h00
`define RST_MASK 8'h3f
`define RST_SIZE 8'h00
`define RST_CFG 8'h00
`define RST_DRIVE_BIT 1'h0
`define RST_SIZE_ERR 1'h1
`define RST_IRQ_STATUS 8'h00
`define RST_IRQ_MASK 8'h00
`define RST_ACTIVE_PREV 6'h00
`define RST_RDATA 8'h00
`define SIZE_NONE 8'h00
`define SIZE_BAD2 8'h02
`define SIZE_BAD4 8'h04
`define IRQ_BIT_SIZE 0
`define IRQ_BIT_SIZE_ERR 1
`define IRQ_BIT_PANEL 2
`define IRQ_BIT_SP_RISE 3
`endif

/* src/sprm_pkg.sv */
// Types shared by the setpoint relay mask register bank.
// Widths are fixed at 8 bits here; nothing is taken from sprm_defs.svh.
package sprm_pkg;
	typedef logic [7:0] reg8_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} bus_req_t;
	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} size_report_t;
endpackage

/* test/sprm_properties.sv */
// Port checker for the setpoint relay mask register bank.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "sprm_defs.svh"
module sprm_properties (
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_addr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic [5:0] i_sp_active,
	input wire logic [5:0] i_relay_state,
	input wire logic i_nv_reinit_done,
	input wire logic [7:0] i_nv_size_probe,
	input wire logic [5:0] o_relay_drive,
	input wire logic [5:0] o_sp_latched,
	input wire logic o_nv_size_error
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	logic [7:0] probe_ff;
	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst)
			probe_ff <= 8'h00;
		else if (i_nv_reinit_done)
			probe_ff <= i_nv_size_probe;
	end
	sequence s_reinit;
		i_nv_reinit_done ##1 (!i_nv_reinit_done) [*2];
	endsequence
	a_view_live: assert property ($past(i_rd && i_addr == `OFS_STATE_VIEW) |->
		o_rdata == {5'h00, $past(i_sp_active[2:0])}) else $error("state view wrong");
	a_drive_pass: assert property (!$past(i_sys_rst) |->
		(o_relay_drive & ~$past(i_sp_active)) == ($past(i_relay_state) & ~$past(i_sp_active)))
		else $error("inactive drive wrong");
	a_drive_gated: assert property (!$past(i_sys_rst) |->
		(o_relay_drive & ~$past(i_relay_state)) == 6'h00) else $error("drive without state");
	a_size_error: assert property (s_reinit |-> o_nv_size_error ==
		!($past(i_nv_size_probe, 2) inside {8'h01, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80}))
		else $error("size error flag wrong");
	a_mask_restore: assert property ($past(i_rd && i_addr == `OFS_RELEASE_MASK) |->
		(o_rdata[5:0] | $past(i_sp_active, 2)) == 6'h3f) else $error("mask not restored");
	a_latch_read: assert property ($past(i_rd && i_addr == `OFS_LATCH_CTRL) |->
		o_rdata == {2'h0, $past(o_sp_latched)}) else $error("latch read wrong");
	a_size_read: assert property ($past(i_rd && i_addr == `OFS_NV_SIZE) |->
		o_rdata == $past(probe_ff)) else $error("size read wrong");
	a_unmapped_zero: assert property ($past(i_rd && i_addr > `OFS_SETPOINT_CFG) |->
		o_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

/* test/setpoint_relay_mask_regs_bench.sv */
// Bench for the setpoint relay mask register bank.
// Drives every port itself; the checker is bound below.
`timescale 1ns/1ps
`include "sprm_defs.svh"
module setpoint_relay_mask_regs_bench;
	logic i_sys_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_nv_reinit_done = 0, o_nv_size_error, o_irq;
	logic [7:0] i_addr = '0, i_wdata = '0, i_nv_size_probe = '0, o_rdata;
	logic [5:0] i_sp_active = '0, i_sp_latch_event = '0, i_relay_state = '0, i_panel_release = '0;
	logic [5:0] o_relay_drive, o_sp_latched;
	int fails = 0, cmp_count = 0;
	setpoint_relay_mask_regs DUT (.*);
	initial forever #10 i_sys_clk = ~i_sys_clk;
	task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr <= 1'h1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'h0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp, string n);
		@(posedge i_sys_clk);
		i_rd <= 1'h1;
		i_addr <= a;
		@(posedge i_sys_clk);
		i_rd <= 1'h0;
		#1 check(n, o_rdata, exp);
	endtask
	task automatic t_mask;
		rd(`OFS_RELEASE_MASK, 8'h3f, "mask");
		rd(`OFS_LATCH_CTRL, 8'h00, "latch");
		wr(`OFS_SETPOINT_CFG, 8'h3f);
		i_sp_active <= 6'h3f;
		i_relay_state <= 6'h3f;
		wr(`OFS_RELEASE_MASK, 8'h3e);
		tick(2);
		check("drive", {2'h0, o_relay_drive}, 8'h3e);
		@(posedge i_sys_clk);
		i_panel_release <= 6'h02;
		@(posedge i_sys_clk);
		i_panel_release <= 6'h00;
		i_sp_active <= 6'h3e;
		tick(2);
		check("drive", {2'h0, o_relay_drive}, 8'h3d);
		rd(`OFS_RELEASE_MASK, 8'h3d, "mask");
	endtask
	task automatic t_latch;
		@(posedge i_sys_clk);
		i_sp_latch_event <= 6'h20;
		@(posedge i_sys_clk);
		i_sp_latch_event <= 6'h00;
		rd(`OFS_LATCH_CTRL, 8'h20, "latch");
		wr(`OFS_LATCH_CTRL, 8'h00);
		rd(`OFS_LATCH_CTRL, 8'h00, "unlatch");
		check("latched", {2'h0, o_sp_latched}, 8'h00);
	endtask
	task automatic t_size;
		logic [7:0] codes [10] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h03};
		foreach (codes[k]) begin
			@(posedge i_sys_clk);
			i_nv_reinit_done <= 1'h1;
			i_nv_size_probe <= codes[k];
			@(posedge i_sys_clk);
			i_nv_reinit_done <= 1'h0;
			wr(`OFS_NV_SIZE, 8'h55);
			rd(`OFS_NV_SIZE, codes[k], "size");
			check("size_err", {7'h00, o_nv_size_error},
				{7'h00, !(codes[k] inside {8'h01, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80})});
		end
		wr(`OFS_STATE_VIEW, 8'hff);
		rd(`OFS_STATE_VIEW, 8'h06, "view");
	endtask
	task automatic t_irq;
		wr(`OFS_IRQ_MASK, 8'h04);
		rd(`OFS_IRQ_STATUS, 8'h0f, "irq_stat");
		wr(`OFS_IRQ_STATUS, 8'h0f);
		tick(1);
		check("irq", {7'h00, o_irq}, 8'h00);
		@(posedge i_sys_clk);
		i_panel_release <= 6'h01;
		@(posedge i_sys_clk);
		i_panel_release <= 6'h00;
		tick(1);
		check("irq", {7'h00, o_irq}, 8'h01);
		wr(`OFS_IRQ_STATUS, 8'h04);
		tick(1);
		check("irq", {7'h00, o_irq}, 8'h00);
		rd(8'hf0, 8'h00, "unmapped");
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge i_sys_clk);
		i_sys_rst <= 1'h0;
		t_mask;
		t_latch;
		t_size;
		t_irq;
		conclude;
	end
	initial begin
		#40000;
		fails++;
		conclude;
	end
endmodule
bind setpoint_relay_mask_regs sprm_properties props (.*);
